// ---- design/ldo_pkg.sv ----
// constants and types for the lcd option command block
`default_nettype none
package ldo_pkg;
   // bus side
   localparam logic [6:0] DEV_ADDR      = 7'h3d;
   localparam logic       READ_BIT      = 1'b1;
   localparam logic [3:0] BYTE_BITS     = 4'h8;
   localparam logic [1:0] IDX_ADDR      = 2'h0;
   localparam logic [1:0] IDX_CMD       = 2'h1;
   localparam logic [1:0] IDX_SETTING   = 2'h2;
   localparam logic [1:0] IDX_EXTRA     = 2'h3;

   // command codes
   localparam logic [7:0] CMD_FRAME     = 8'h86;
   localparam logic [7:0] CMD_BLINK     = 8'h88;
   localparam logic [7:0] CMD_IVA       = 8'h8a;

   // field layout
   localparam int         FRAME_BIT     = 0;
   localparam int         BLINK_W       = 2;
   localparam int         PIN_SEL_BIT   = 5;
   localparam int         ADJ_EN_BIT    = 4;
   localparam int         TRIM_W        = 4;
   localparam logic [3:0] TRIM_OFF      = 4'h0;

   // blink rate encodings
   localparam logic [1:0] BLINK_OFF     = 2'h0;
   localparam logic [1:0] BLINK_2HZ     = 2'h1;
   localparam logic [1:0] BLINK_1HZ     = 2'h2;
   localparam logic [1:0] BLINK_HALF_HZ = 2'h3;

   // values after reset
   localparam logic       FRAME_RST     = 1'b0;
   localparam logic [7:0] BLINK_RST     = 8'h00;
   localparam logic [7:0] IVA_RST       = 8'h30;

   // timing
   localparam int         CLOCK_HZ          = 20_000_000;
   localparam int         FRAME_SLOW_HZ     = 80;
   localparam int         FRAME_FAST_HZ     = 160;
   localparam int         BLINK_STEP_MS     = 250;
   localparam int         FRAME_SLOW_CYCLES = CLOCK_HZ / FRAME_SLOW_HZ;
   localparam int         FRAME_FAST_CYCLES = CLOCK_HZ / FRAME_FAST_HZ;
   localparam int         BLINK_STEP_CYCLES =
                             (CLOCK_HZ / 1000) * BLINK_STEP_MS;
   localparam int         CNT_W             = 24;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RX,
      ST_ACK,
      ST_SKIP
   } ldo_bus_state_type;
endpackage : ldo_pkg
`default_nettype wire

// ---- design/ldo_option_cmd.sv ----
// serial command decoder and option settings for the lcd controller
`default_nettype none

module ldo_option_cmd #(
   parameter int FRAME_SLOW_CYCLES_P = ldo_pkg::FRAME_SLOW_CYCLES,
   parameter int FRAME_FAST_CYCLES_P = ldo_pkg::FRAME_FAST_CYCLES,
   parameter int BLINK_STEP_CYCLES_P = ldo_pkg::BLINK_STEP_CYCLES
) (
   input  wire logic                        clock_in,
   input  wire logic                        resetn_in,
   input  wire logic                        scl_in,
   input  wire logic                        sda_in,
   input  wire logic                        display_on_in,
   output logic                             sda_out,
   output logic                             sda_oe_out,
   output logic                             frame_rate_sel_out,
   output logic [ldo_pkg::BLINK_W-1:0]      blink_rate_sel_out,
   output logic                             shared_pin_select_out,
   output logic                             voltage_adjust_enable_out,
   output logic [ldo_pkg::TRIM_W-1:0]       voltage_trim_code_out,
   output logic                             bias_follower_amp_out,
   output logic                             frame_tick_out,
   output logic                             display_blank_out
);
   import ldo_pkg::*;

   localparam logic [CNT_W-1:0] SLOW_LAST = CNT_W'(FRAME_SLOW_CYCLES_P - 1);
   localparam logic [CNT_W-1:0] FAST_LAST = CNT_W'(FRAME_FAST_CYCLES_P - 1);
   localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(BLINK_STEP_CYCLES_P - 1);

   // follower is off for a zero trim, and for segment pin with adjust off
   function automatic logic amp_on(input logic [7:0] internal_voltage_adjust);
      amp_on = (internal_voltage_adjust[TRIM_W-1:0] != TRIM_OFF) &&
               !(internal_voltage_adjust[PIN_SEL_BIT] && !internal_voltage_adjust[ADJ_EN_BIT]);
   endfunction : amp_on

   // blank half of each blink period; phase counts quarter seconds
   function automatic logic blink_dark(input logic [1:0] sel,
                                       input logic [2:0] phase);
      unique case (sel)
         BLINK_OFF:     blink_dark = 1'b0;
         BLINK_2HZ:     blink_dark = phase[0];
         BLINK_1HZ:     blink_dark = phase[1];
         BLINK_HALF_HZ: blink_dark = phase[2];
      endcase
   endfunction : blink_dark

   // pin synchronisers; stage one feeds stage two only
   logic [2:0] scl_sync_ff;
   logic [2:0] sda_sync_ff;
   logic [2:0] nxt_scl_sync;
   logic [2:0] nxt_sda_sync;

   always_comb begin
      nxt_scl_sync = {scl_sync_ff[1:0], scl_in};
      nxt_sda_sync = {sda_sync_ff[1:0], sda_in};
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         scl_sync_ff <= 3'h7;
         sda_sync_ff <= 3'h7;
      end else begin
         scl_sync_ff <= nxt_scl_sync;
         sda_sync_ff <= nxt_sda_sync;
      end
   end

   logic scl_q;
   logic scl_d;
   logic sda_q;
   logic sda_d;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   always_comb begin
      scl_q     = scl_sync_ff[1];
      scl_d     = scl_sync_ff[2];
      sda_q     = sda_sync_ff[1];
      sda_d     = sda_sync_ff[2];
      scl_rise  = scl_q && !scl_d;
      scl_fall  = !scl_q && scl_d;
      start_det = scl_q && scl_d && sda_d && !sda_q;
      stop_det  = scl_q && scl_d && !sda_d && sda_q;
   end

   // bus receiver
   ldo_bus_state_type state_ff;
   ldo_bus_state_type nxt_state;
   logic [3:0]        bit_cnt_ff;
   logic [3:0]        nxt_bit_cnt;
   logic [7:0]        shift_ff;
   logic [7:0]        nxt_shift;
   logic [1:0]        byte_idx_ff;
   logic [1:0]        nxt_byte_idx;
   logic [7:0]        cmd_ff;
   logic [7:0]        nxt_cmd;
   logic [7:0]        setting_ff;
   logic [7:0]        nxt_setting;
   logic              have_ff;
   logic              nxt_have;
   logic              ack_ff;
   logic              nxt_ack;

   always_comb begin
      nxt_state    = state_ff;
      nxt_bit_cnt  = bit_cnt_ff;
      nxt_shift    = shift_ff;
      nxt_byte_idx = byte_idx_ff;
      nxt_cmd      = cmd_ff;
      nxt_setting  = setting_ff;
      nxt_have     = have_ff;
      nxt_ack      = ack_ff;
      if (start_det) begin
         // a repeated start drops any half-written setting
         nxt_state    = ST_RX;
         nxt_bit_cnt  = 4'h0;
         nxt_byte_idx = IDX_ADDR;
         nxt_have     = 1'b0;
         nxt_ack      = 1'b0;
      end else if (stop_det) begin
         nxt_state = ST_IDLE;
         nxt_have  = 1'b0;
         nxt_ack   = 1'b0;
      end else begin
         unique case (state_ff)
            ST_IDLE, ST_SKIP: begin
            end
            ST_RX: begin
               if (scl_rise && bit_cnt_ff != BYTE_BITS) begin
                  nxt_shift   = {shift_ff[6:0], sda_q};
                  nxt_bit_cnt = bit_cnt_ff + 4'h1;
               end else if (scl_fall && bit_cnt_ff == BYTE_BITS) begin
                  if (byte_idx_ff == IDX_ADDR &&
                      shift_ff[7:1] != DEV_ADDR) begin
                     nxt_state = ST_SKIP;
                  end else begin
                     nxt_state = ST_ACK;
                     nxt_ack   = 1'b1;
                     if (byte_idx_ff == IDX_CMD) begin
                        nxt_cmd = shift_ff;
                     end
                     if (byte_idx_ff == IDX_SETTING) begin
                        nxt_setting = shift_ff;
                        nxt_have    = 1'b1;
                     end
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  nxt_ack     = 1'b0;
                  nxt_bit_cnt = 4'h0;
                  // reads are not served: release the bus after the ack
                  if (byte_idx_ff == IDX_ADDR && shift_ff[0] == READ_BIT)
                  begin
                     nxt_state = ST_SKIP;
                  end else begin
                     nxt_state = ST_RX;
                  end
                  if (byte_idx_ff != IDX_EXTRA) begin
                     nxt_byte_idx = byte_idx_ff + 2'h1;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_ff    <= ST_IDLE;
         bit_cnt_ff  <= 4'h0;
         shift_ff    <= 8'h00;
         byte_idx_ff <= IDX_ADDR;
         cmd_ff      <= 8'h00;
         setting_ff  <= 8'h00;
         have_ff     <= 1'b0;
         ack_ff      <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         bit_cnt_ff  <= nxt_bit_cnt;
         shift_ff    <= nxt_shift;
         byte_idx_ff <= nxt_byte_idx;
         cmd_ff      <= nxt_cmd;
         setting_ff  <= nxt_setting;
         have_ff     <= nxt_have;
         ack_ff      <= nxt_ack;
      end
   end

   // option settings, committed at the stop that closes the write
   logic       frame_ff;
   logic       nxt_frame;
   logic [1:0] blink_ff;
   logic [1:0] nxt_blink;
   logic [7:0] iva_ff;
   logic [7:0] nxt_iva;
   logic       amp_ff;
   logic       nxt_amp;

   always_comb begin
      nxt_frame = frame_ff;
      nxt_blink = blink_ff;
      nxt_iva   = iva_ff;
      if (stop_det && have_ff) begin
         case (cmd_ff)
            CMD_FRAME: nxt_frame = setting_ff[FRAME_BIT];
            CMD_BLINK: nxt_blink = setting_ff[BLINK_W-1:0];
            CMD_IVA:   nxt_iva   = {2'h0, setting_ff[5:0]};
            default: begin
            end
         endcase
      end
      nxt_amp = amp_on(nxt_iva);
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         frame_ff <= FRAME_RST;
         blink_ff <= BLINK_RST[BLINK_W-1:0];
         iva_ff   <= IVA_RST;
         amp_ff   <= 1'b0;
      end else begin
         frame_ff <= nxt_frame;
         blink_ff <= nxt_blink;
         iva_ff   <= nxt_iva;
         amp_ff   <= nxt_amp;
      end
   end

   // frame and blink dividers
   logic [CNT_W-1:0] frame_cnt_ff;
   logic [CNT_W-1:0] nxt_frame_cnt;
   logic             tick_ff;
   logic             nxt_tick;
   logic [CNT_W-1:0] step_cnt_ff;
   logic [CNT_W-1:0] nxt_step_cnt;
   logic [2:0]       phase_ff;
   logic [2:0]       nxt_phase;
   logic             blank_ff;
   logic             nxt_blank;
   logic [CNT_W-1:0] frame_last;

   always_comb begin
      frame_last    = frame_ff ? FAST_LAST : SLOW_LAST;
      nxt_frame_cnt = frame_cnt_ff + 1'b1;
      nxt_tick      = 1'b0;
      // >= so a switch to the fast rate never overruns the count
      if (frame_cnt_ff >= frame_last) begin
         nxt_frame_cnt = '0;
         nxt_tick      = 1'b1;
      end
      nxt_step_cnt = step_cnt_ff + 1'b1;
      nxt_phase    = phase_ff;
      if (step_cnt_ff == STEP_LAST) begin
         nxt_step_cnt = '0;
         nxt_phase    = phase_ff + 3'h1;
      end
      nxt_blank = !display_on_in ||
                  blink_dark(blink_ff, phase_ff);
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         frame_cnt_ff <= '0;
         tick_ff      <= 1'b0;
         step_cnt_ff  <= '0;
         phase_ff     <= 3'h0;
         blank_ff     <= 1'b1;
      end else begin
         frame_cnt_ff <= nxt_frame_cnt;
         tick_ff      <= nxt_tick;
         step_cnt_ff  <= nxt_step_cnt;
         phase_ff     <= nxt_phase;
         blank_ff     <= nxt_blank;
      end
   end

   // open drain: only ever pulls low
   assign sda_out                   = 1'b0;
   assign sda_oe_out                = ack_ff;
   assign frame_rate_sel_out        = frame_ff;
   assign blink_rate_sel_out        = blink_ff;
   assign shared_pin_select_out     = iva_ff[PIN_SEL_BIT];
   assign voltage_adjust_enable_out = iva_ff[ADJ_EN_BIT];
   assign voltage_trim_code_out     = iva_ff[TRIM_W-1:0];
   assign bias_follower_amp_out     = amp_ff;
   assign frame_tick_out            = tick_ff;
   assign display_blank_out         = blank_ff;
endmodule : ldo_option_cmd
`default_nettype wire

// ---- test/ldo_option_cmd_chk.sv ----
// property checker bound to the lcd option command block
`default_nettype none
module ldo_option_cmd_chk #(
   parameter int FRAME_SLOW_CYCLES_P = 16,
   parameter int FRAME_FAST_CYCLES_P = 8,
   parameter int BLINK_STEP_CYCLES_P = 10
) (
   input wire logic                    clock_in,
   input wire logic                    resetn_in,
   input wire logic                    scl_in,
   input wire logic                    sda_in,
   input wire logic                    display_on_in,
   input wire logic                    sda_out,
   input wire logic                    sda_oe_out,
   input wire logic                    frame_rate_sel_out,
   input wire logic [ldo_pkg::BLINK_W-1:0] blink_rate_sel_out,
   input wire logic                    shared_pin_select_out,
   input wire logic                    voltage_adjust_enable_out,
   input wire logic [ldo_pkg::TRIM_W-1:0]  voltage_trim_code_out,
   input wire logic                    bias_follower_amp_out,
   input wire logic                    frame_tick_out,
   input wire logic                    display_blank_out
);
   timeunit 1ns;
   timeprecision 100ps;
   import ldo_pkg::*;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!resetn_in);
   int   gap_ff;
   logic seen_ff;
   logic chg_ff;
   // a rate change mid-period leaves that period's length open
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         gap_ff  <= 0;
         seen_ff <= 1'b0;
         chg_ff  <= 1'b0;
      end else if (frame_tick_out) begin
         gap_ff  <= 0;
         seen_ff <= 1'b1;
         chg_ff  <= 1'b0;
      end else begin
         gap_ff  <= gap_ff + 1;
         chg_ff  <= chg_ff | (frame_rate_sel_out != $past(frame_rate_sel_out));
      end
   end
   amp_rule_a: assert property (
      bias_follower_amp_out == (voltage_trim_code_out != TRIM_OFF &&
      !(shared_pin_select_out && !voltage_adjust_enable_out)))
      else $error("follower enable wrong");
   frame_period_a: assert property (
      frame_tick_out && seen_ff && !chg_ff && $stable(frame_rate_sel_out)
      |-> gap_ff == (frame_rate_sel_out ? FRAME_FAST_CYCLES_P
      : FRAME_SLOW_CYCLES_P) - 1)
      else $error("frame period wrong");
   blank_off_a: assert property (
      !display_on_in |=> display_blank_out) else $error("blank not set");
   blank_steady_a: assert property (
      display_on_in && blink_rate_sel_out == BLINK_OFF |=> !display_blank_out)
      else $error("blank without blink");
   ack_low_scl_a: assert property (
      $changed(sda_oe_out) |-> !scl_in) else $error("ack moved in clock high");
   ack_hold_a: assert property (
      $rose(sda_oe_out) |-> sda_oe_out[*8]) else $error("ack too short");
   sda_low_a: assert property (
      sda_out == 1'b0) else $error("data out not low");
   commit_stop_a: assert property (
      $changed({frame_rate_sel_out, blink_rate_sel_out, shared_pin_select_out,
      voltage_adjust_enable_out, voltage_trim_code_out}) |-> scl_in && sda_in
      && $past(scl_in, 4)) else $error("setting changed outside stop");
   one_option_a: assert property (
      $changed(blink_rate_sel_out) |-> $stable({frame_rate_sel_out,
      shared_pin_select_out, voltage_adjust_enable_out, voltage_trim_code_out}))
      else $error("two options changed");
   cover property ($rose(sda_oe_out));
   cover property ($changed(voltage_trim_code_out));
   cover property (frame_tick_out && frame_rate_sel_out);
endmodule : ldo_option_cmd_chk
bind ldo_option_cmd ldo_option_cmd_chk #(
   .FRAME_SLOW_CYCLES_P(FRAME_SLOW_CYCLES_P),
   .FRAME_FAST_CYCLES_P(FRAME_FAST_CYCLES_P),
   .BLINK_STEP_CYCLES_P(BLINK_STEP_CYCLES_P)
) chk_i (
   .clock_in(clock_in), .resetn_in(resetn_in), .scl_in(scl_in),
   .sda_in(sda_in), .display_on_in(display_on_in), .sda_out(sda_out),
   .sda_oe_out(sda_oe_out), .frame_rate_sel_out(frame_rate_sel_out),
   .blink_rate_sel_out(blink_rate_sel_out),
   .shared_pin_select_out(shared_pin_select_out),
   .voltage_adjust_enable_out(voltage_adjust_enable_out),
   .voltage_trim_code_out(voltage_trim_code_out),
   .bias_follower_amp_out(bias_follower_amp_out),
   .frame_tick_out(frame_tick_out), .display_blank_out(display_blank_out)
);
`default_nettype wire

// ---- test/ldo_host_model.sv ----
// host model that writes option commands over the two-wire bus
`default_nettype none
module ldo_host_model #(
   parameter int HALF = 8
) (
   input  wire logic clock_in,
   input  wire logic sda_in,
   output var logic  scl_out,
   output var logic  sda_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // sda_out high means released; the pull-up gives the level
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask : step
   // data only moves while the clock is low
   task automatic put_bit(input logic b);
      step(2);
      sda_out = b;
      step(HALF);
      scl_out = 1'b1;
      step(HALF);
      scl_out = 1'b0;
   endtask : put_bit
   task automatic put_byte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      step(2);
      sda_out = 1'b1;
      step(HALF);
      scl_out = 1'b1;
      step(HALF / 2);
      ack = !sda_in;
      step(HALF / 2);
      scl_out = 1'b0;
   endtask : put_byte
   task automatic write3(input logic [7:0] a, input logic [7:0] c,
                         input logic [7:0] s, output logic [2:0] acks);
      step(HALF);
      sda_out = 1'b0;
      step(HALF);
      scl_out = 1'b0;
      put_byte(a, acks[2]);
      put_byte(c, acks[1]);
      put_byte(s, acks[0]);
      step(2);
      sda_out = 1'b0;
      step(HALF);
      scl_out = 1'b1;
      step(HALF);
      sda_out = 1'b1;
      step(HALF);
   endtask : write3
endmodule : ldo_host_model
`default_nettype wire

// ---- test/tb_ldo_option_cmd.sv ----
// self-checking bench for the lcd option command block
`default_nettype none
module tb_ldo_option_cmd;
   timeunit 1ns;
   timeprecision 100ps;
   import ldo_pkg::*;
   localparam int SLOW = 16;
   localparam int FAST = 8;
   localparam int STEP = 10;
   logic       clock_in = 1'b0;
   logic       resetn_in = 1'b0;
   logic       display_on_in = 1'b0;
   logic       scl, host_sda, sda_oe, sda_o, sda;
   logic       frame, tick, pin, adj, amp, blank, e_frame;
   logic [1:0] blink, e_blink;
   logic [3:0] trim;
   logic [2:0] acks;
   logic [7:0] e_iva;
   logic [7:0] iva_tab [5] = '{8'hc5, 8'h2f, 8'h31, 8'h00, 8'h10};
   int         fail_count = 0;
   int         n_tests = 0;
   assign sda = host_sda & ~sda_oe;
   initial begin
      forever #25 clock_in = ~clock_in;
   end
   ldo_option_cmd #(.FRAME_SLOW_CYCLES_P(SLOW), .FRAME_FAST_CYCLES_P(FAST),
      .BLINK_STEP_CYCLES_P(STEP)) ldo_option_cmd_i (
      .clock_in(clock_in), .resetn_in(resetn_in), .scl_in(scl),
      .sda_in(sda), .display_on_in(display_on_in), .sda_out(sda_o),
      .sda_oe_out(sda_oe), .frame_rate_sel_out(frame),
      .blink_rate_sel_out(blink), .shared_pin_select_out(pin),
      .voltage_adjust_enable_out(adj), .voltage_trim_code_out(trim),
      .bias_follower_amp_out(amp), .frame_tick_out(tick),
      .display_blank_out(blank));
   ldo_host_model ldo_host_model_i (.clock_in(clock_in), .sda_in(sda),
      .scl_out(scl), .sda_out(host_sda));
   task automatic stop_test();
      if (fail_count == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_set();
      chk({frame, blink, pin, adj, trim, amp}, {e_frame, e_blink, e_iva[5:0],
          e_iva[3:0] != 4'h0 && !(e_iva[5] && !e_iva[4])});
   endtask : chk_set
   task automatic wr(input logic [7:0] c, input logic [7:0] s);
      ldo_host_model_i.write3({DEV_ADDR, 1'b0}, c, s, acks);
      chk(acks, 3'b111);
      if (c == CMD_FRAME) e_frame = s[0];
      if (c == CMD_BLINK) e_blink = s[1:0];
      if (c == CMD_IVA) e_iva = s & 8'h3f;
      chk_set();
   endtask : wr
   // counts cycles between two ticks, or two changes of blank
   task automatic period(input bit use_blank, input int exp);
      logic prev;
      int   n;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         prev = blank;
         do begin
            ldo_host_model_i.step(1);
            n++;
            if (n > 1000) begin
               fail_count++;
               stop_test();
            end
         end while (use_blank ? blank === prev : tick !== 1'b1);
      end
      chk(n, exp);
   endtask : period
   initial begin
      e_frame = 1'b0;
      e_blink = 2'h0;
      e_iva = 8'h30;
      repeat (4) @(posedge clock_in);
      #1 resetn_in = 1'b1;
      ldo_host_model_i.step(4);
      chk_set();
      display_on_in = 1'b1;
      for (int b = 0; b < 4; b++) wr(CMD_BLINK, 8'hfc | 8'(b));
      for (int i = 0; i < 5; i++) wr(CMD_IVA, iva_tab[i]);
      wr(CMD_FRAME, 8'hff);
      period(1'b0, FAST);
      wr(CMD_FRAME, 8'hfe);
      period(1'b0, SLOW);
      ldo_host_model_i.write3({DEV_ADDR, 1'b0}, 8'h8c, 8'hff, acks);
      chk(acks, 3'b111);
      chk_set();
      ldo_host_model_i.write3({7'h3c, 1'b0}, CMD_BLINK, 8'h01, acks);
      chk(acks, 3'b000);
      chk_set();
      // read request: address acked, rest of the frame ignored
      ldo_host_model_i.write3({DEV_ADDR, READ_BIT}, CMD_BLINK, 8'h01,
         acks);
      chk(acks, 3'b100);
      chk_set();
      for (int b = 1; b < 4; b++) begin
         wr(CMD_BLINK, 8'(b));
         period(1'b1, STEP << (b - 1));
      end
      display_on_in = 1'b0;
      ldo_host_model_i.step(2);
      chk(blank, 1'b1);
      display_on_in = 1'b1;
      wr(CMD_BLINK, 8'h00);
      ldo_host_model_i.step(2);
      chk(blank, 1'b0);
      stop_test();
   end
endmodule : tb_ldo_option_cmd
`default_nettype wire
